// file: src/ucfic_channel.sv
`timescale 1ns/1ps
`include "ucfic_consts.svh"
module ucfic_channel (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire ucfic_pkg::ucfic_req_s reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       send_request_n,
  output logic                       terminal_ready_n,
  input  wire logic                  clear_to_send_n,
  input  wire logic                  data_set_ready_n,
  input  wire logic                  ring_detect_n,
  input  wire logic                  carrier_detect_n
);
  import ucfic_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic hit(input ucfic_req_s r, input logic [2:0] a);
    return r.addr == a;
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [5:0] f);
    logic [7:0] m;
    m = d & (8'hff >> (2'd3 - f[1:0]));
    if (f[5]) return ~f[4];
    return f[4] ? ^m : ~^m;
  endfunction

  function automatic logic [4:0] trig_of(input logic en, input logic [1:0] sel);
    if (!en) return 5'd1;
    case (sel)
      2'b00:   return 5'd1;
      2'b01:   return 5'd4;
      2'b10:   return 5'd8;
      default: return 5'd14;
    endcase
  endfunction

  // Four character periods in oversample ticks
  function automatic logic [9:0] tout_ticks(input logic [7:0] f);
    logic [3:0] bits;
    bits = `UCF_CHAR_BASE + {2'h0, f[1:0]} + {3'h0, f[3]} + {3'h0, f[2]};
    return {bits, 6'h00};
  endfunction

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [4:0] interrupt_enables;
  logic       fifo_en;
  logic [1:0] trig_sel;
  logic [7:0] character_format;
  logic [5:0] modem_line_control;
  logic [7:0] scr;

  wire wr_data  = reg_req.wr && hit(reg_req, `UCF_OFF_DATA);
  wire wr_ien   = reg_req.wr && hit(reg_req, `UCF_OFF_IEN);
  wire wr_qctl  = reg_req.wr && hit(reg_req, `UCF_OFF_QCTL);
  wire wr_fmt   = reg_req.wr && hit(reg_req, `UCF_OFF_FMT);
  wire wr_mlc   = reg_req.wr && hit(reg_req, `UCF_OFF_MLC);
  wire wr_scr   = reg_req.wr && hit(reg_req, `UCF_OFF_SCR);
  wire rd_data  = reg_req.rd && hit(reg_req, `UCF_OFF_DATA);
  wire rd_isr   = reg_req.rd && hit(reg_req, `UCF_OFF_QCTL);
  wire rd_lcond = reg_req.rd && hit(reg_req, `UCF_OFF_LCOND);
  wire rd_mls   = reg_req.rd && hit(reg_req, `UCF_OFF_MLS);
  wire loop     = modem_line_control[`UCF_MC_LOOP];
  wire afc      = modem_line_control[`UCF_MC_AFC];

  wire mode_chg = wr_qctl && reg_req.wdata[`UCF_QC_EN] != fifo_en;
  wire rx_flush = (wr_qctl && reg_req.wdata[`UCF_QC_RXFL] && reg_req.wdata[`UCF_QC_EN])
                  || mode_chg;
  wire tx_flush = wr_qctl && reg_req.wdata[`UCF_QC_TXFL] && reg_req.wdata[`UCF_QC_EN];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interrupt_enables      <= 5'h00;
      fifo_en  <= 1'b0;
      trig_sel <= 2'b00;
      character_format      <= `UCF_RST_BYTE;
      modem_line_control      <= 6'h00;
      scr      <= `UCF_RST_BYTE;
    end else begin
      if (wr_ien) interrupt_enables <= reg_req.wdata[4:0];
      if (wr_qctl) begin
        fifo_en  <= reg_req.wdata[`UCF_QC_EN];
        trig_sel <= reg_req.wdata[`UCF_QC_TRIG];
      end
      if (wr_fmt) character_format <= reg_req.wdata;
      if (wr_mlc) modem_line_control <= reg_req.wdata[5:0];
      if (wr_scr) scr <= reg_req.wdata;
    end
  end

  // ****************************************
  // Queues and transmit buffer
  // ****************************************
  wire [4:0]  cap     = fifo_en ? `UCF_CAP_FIFO : `UCF_CAP_BYTE;
  wire [4:0]  trig    = trig_of(fifo_en, trig_sel);
  logic       rx_req;
  ucfic_rx_s  rx_new;
  ucfic_rx_s  rx_q;
  logic [4:0] rx_cnt;
  logic       rx_wready;
  wire        rx_pop  = rd_data && rx_cnt != 5'h00;
  wire        rx_push = rx_req && rx_wready;
  logic [7:0] tx_q;
  logic [4:0] tx_cnt;
  logic       sk_ready;
  logic       sk_valid;
  logic [7:0] sk_data;
  logic       sh_ready;

  ucfic_fifo #(.W($bits(ucfic_rx_s))) u_rxq (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .flush    (rx_flush),
    .cap      (cap),
    .push     (rx_req),
    .din      (rx_new),
    .pop      (rx_pop),
    .wr_ready (rx_wready),
    .q        (rx_q),
    .count    (rx_cnt)
  );

  ucfic_fifo #(.W(8)) u_txq (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .flush    (tx_flush),
    .cap      (cap),
    .push     (wr_data),
    .din      (reg_req.wdata),
    .pop      (sk_ready),
    .wr_ready (),
    .q        (tx_q),
    .count    (tx_cnt)
  );

  ucfic_skid u_skid (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (tx_flush),
    .in_valid  (tx_cnt != 5'h00),
    .in_ready  (sk_ready),
    .in_data   (tx_q),
    .out_valid (sk_valid),
    .out_ready (sh_ready),
    .out_data  (sk_data)
  );

  // ****************************************
  // Baud divider and modem lines
  // ****************************************
  logic [15:0] div_cnt;
  wire         tick = div_cnt == `UCF_BAUD_LAST;

  always_ff @(posedge clock) begin
    if (sys_rst || tick) div_cnt <= 16'h0000;
    else div_cnt <= div_cnt + 16'h0001;
  end

  wire [3:0] m_now = loop ? {modem_line_control[3], modem_line_control[2], modem_line_control[0], modem_line_control[1]}
                          : {~carrier_detect_n, ~ring_detect_n,
                             ~data_set_ready_n, ~clear_to_send_n};
  logic [3:0] m_prev;
  logic       m_armed;
  logic [3:0] delta;
  wire  [3:0] m_chg = {m_now[3] ^ m_prev[3], m_prev[2] & ~m_now[2],
                       m_now[1:0] ^ m_prev[1:0]} & {4{m_armed}};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      m_prev  <= 4'h0;
      m_armed <= 1'b0;
      delta   <= 4'h0;
    end else begin
      m_prev  <= m_now;
      m_armed <= 1'b1;
      delta   <= (rd_mls ? 4'h0 : delta) | m_chg;
    end
  end

  // Flow-control hysteresis on request-to-send
  logic rts_hold;
  always_ff @(posedge clock) begin
    if (sys_rst || !afc) rts_hold <= 1'b0;
    else if (rx_cnt >= trig) rts_hold <= 1'b1;
    else if (rx_cnt < `UCF_RESUME) rts_hold <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      terminal_ready_n <= 1'b1;
      send_request_n   <= 1'b1;
    end else begin
      terminal_ready_n <= loop || !modem_line_control[`UCF_MC_DTR];
      send_request_n   <= loop || !modem_line_control[`UCF_MC_RTS] || rts_hold;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  ucfic_sh_e  tx_st;
  logic [7:0] tx_sh;
  logic [2:0] tx_bit;
  logic [5:0] tx_tk;
  logic       tx_par;
  wire  [2:0] last_bit  = {1'b1, character_format[`UCF_FMT_LEN]};
  wire  [5:0] stop_last = !character_format[`UCF_FMT_STOP] ? `UCF_BIT_LAST :
                          (character_format[1:0] == 2'b00) ? `UCF_STOP15 : `UCF_STOP2;
  wire        bit_end   = tick && tx_tk == `UCF_BIT_LAST;

  assign sh_ready = tx_st == SH_IDLE && (!afc || m_now[0]);
  wire tx_line = (tx_st == SH_START) ? 1'b0 :
                 (tx_st == SH_DATA)  ? tx_sh[0] :
                 (tx_st == SH_PAR)   ? tx_par : 1'b1;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st <= SH_IDLE;
      tx_sh <= 8'h00;
      tx_bit <= 3'h0;
      tx_tk <= 6'h00;
      tx_par <= 1'b0;
    end else if (tx_st == SH_IDLE) begin
      if (sk_valid && sh_ready) begin
        tx_st  <= SH_START;
        tx_sh  <= sk_data;
        tx_par <= par_bit(sk_data, character_format[5:0]);
        tx_tk  <= 6'h00;
        tx_bit <= 3'h3 - {1'b0, character_format[1:0]};
      end
    end else if (tx_st == SH_STOP) begin
      if (tick) tx_tk <= tx_tk + 6'h01;
      if (tick && tx_tk == stop_last) tx_st <= SH_IDLE;
    end else if (tick) begin
      tx_tk <= bit_end ? 6'h00 : tx_tk + 6'h01;
      if (bit_end) begin
        case (tx_st)
          SH_START: tx_st <= SH_DATA;
          SH_DATA: begin
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) tx_st <= character_format[`UCF_FMT_PEN] ? SH_PAR : SH_STOP;
          end
          default: tx_st <= SH_STOP;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) serial_out <= 1'b1;
    else serial_out <= loop || (!character_format[`UCF_FMT_BRK] && tx_line);
  end

  // ****************************************
  // Receiver
  // ****************************************
  ucfic_sh_e  rx_st;
  logic [7:0] rx_sh;
  logic [2:0] rx_bit;
  logic [3:0] rx_tk;
  logic       rx_pb;
  wire        rx_in   = loop ? tx_line : serial_in;
  wire  [7:0] rx_dat  = rx_sh >> (2'd3 - character_format[1:0]);
  wire        rx_mid  = tick && rx_tk == 4'hf;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_st  <= SH_IDLE;
      rx_sh  <= 8'h00;
      rx_bit <= 3'h0;
      rx_tk  <= 4'h0;
      rx_pb  <= 1'b0;
      rx_req <= 1'b0;
      rx_new <= '0;
    end else begin
      rx_req <= 1'b0;
      if (tick) rx_tk <= rx_tk + 4'h1;
      case (rx_st)
        SH_IDLE: begin
          rx_tk <= 4'h0;
          rx_pb <= 1'b0;
          if (tick && !rx_in) rx_st <= SH_START;
        end
        SH_START: if (tick && rx_tk == `UCF_MID_TICK) begin
          rx_tk  <= 4'h0;
          rx_bit <= 3'h0;
          rx_st  <= rx_in ? SH_IDLE : SH_DATA;
        end
        SH_DATA: if (rx_mid) begin
          rx_sh  <= {rx_in, rx_sh[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == last_bit) rx_st <= character_format[`UCF_FMT_PEN] ? SH_PAR : SH_STOP;
        end
        SH_PAR: if (rx_mid) begin
          rx_pb <= rx_in;
          rx_st <= SH_STOP;
        end
        SH_STOP: if (rx_mid) begin
          rx_req      <= 1'b1;
          rx_new.data <= rx_dat;
          rx_new.ferr <= !rx_in;
          rx_new.perr <= character_format[`UCF_FMT_PEN] && rx_pb != par_bit(rx_dat, character_format[5:0]);
          rx_new.brk  <= rx_dat == 8'h00 && !rx_pb && !rx_in;
          rx_st       <= (rx_dat == 8'h00 && !rx_pb && !rx_in) ? SH_BRKW : SH_IDLE;
        end
        SH_BRKW: if (rx_in) rx_st <= SH_IDLE;
        default: rx_st <= SH_IDLE;
      endcase
    end
  end

  // ****************************************
  // Line condition flags and timeout
  // ****************************************
  logic       oe, pe, fe, bi, derr;
  logic       head_new;
  logic       to_pend;
  logic [9:0] to_cnt;
  wire        new_head = (rx_push && (rx_cnt == 5'h00 || (rx_pop && rx_cnt == 5'h01)))
                         || (rx_pop && rx_cnt > 5'h01);
  wire        head_err = head_new && rx_cnt != 5'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {oe, pe, fe, bi, derr} <= 5'h00;
      head_new <= 1'b0;
    end else begin
      head_new <= new_head && !rx_flush;
      oe   <= (oe && !rd_lcond) || (rx_req && !rx_wready);
      pe   <= (pe && !rd_lcond) || (head_err && rx_q.perr);
      fe   <= (fe && !rd_lcond) || (head_err && rx_q.ferr);
      bi   <= (bi && !rd_lcond) || (head_err && rx_q.brk);
      derr <= (derr && !rd_lcond) || (head_err && (rx_q.perr || rx_q.ferr || rx_q.brk));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || rx_pop || rx_cnt == 5'h00 || !fifo_en) begin
      to_cnt  <= 10'h000;
      to_pend <= 1'b0;
    end else if (rx_push) begin
      to_cnt <= 10'h000;
    end else if (tick && !to_pend) begin
      to_cnt  <= to_cnt + 10'h001;
      to_pend <= to_cnt == tout_ticks(character_format) - 10'h001;
    end
  end

  // ****************************************
  // Interrupt source encoding
  // ****************************************
  logic       transmit_holding_vacant_pend;
  logic       tx_below_d;
  wire        tx_below = tx_cnt < `UCF_TX_TRIG;
  wire        rls_act  = interrupt_enables[2] && (oe || pe || fe || bi);
  wire        rda_act  = interrupt_enables[0] && rx_cnt >= trig && rx_cnt != 5'h00;
  wire        to_act   = interrupt_enables[0] && to_pend;
  wire        transmit_holding_vacant_act = interrupt_enables[1] && transmit_holding_vacant_pend;
  wire        ms_act   = interrupt_enables[3] && delta != 4'h0;
  ucfic_isr_e isr_code;

  assign isr_code = rls_act  ? ISR_RLS  :
                    rda_act  ? ISR_RDA  :
                    to_act   ? ISR_TOUT :
                    transmit_holding_vacant_act ? ISR_TRANSMIT_HOLDING_VACANT :
                    ms_act   ? ISR_MODEM : ISR_NONE;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      transmit_holding_vacant_pend  <= 1'b0;
      tx_below_d <= 1'b1;
    end else begin
      tx_below_d <= tx_below;
      if (tx_below && !tx_below_d) transmit_holding_vacant_pend <= 1'b1;
      else if (!tx_below || (rd_isr && isr_code == ISR_TRANSMIT_HOLDING_VACANT)) transmit_holding_vacant_pend <= 1'b0;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  wire [7:0] lsr_val = {derr, tx_cnt == 5'h00 && !sk_valid && tx_st == SH_IDLE,
                        tx_cnt == 5'h00, bi, fe, pe, oe, rx_cnt != 5'h00};
  wire [7:0] rd_mux  =
    hit(reg_req, `UCF_OFF_DATA)  ? rx_q.data :
    hit(reg_req, `UCF_OFF_IEN)   ? {3'h0, interrupt_enables} :
    hit(reg_req, `UCF_OFF_QCTL)  ? {fifo_en, fifo_en, isr_code} :
    hit(reg_req, `UCF_OFF_FMT)   ? character_format :
    hit(reg_req, `UCF_OFF_MLC)   ? {2'b00, modem_line_control} :
    hit(reg_req, `UCF_OFF_LCOND) ? lsr_val :
    hit(reg_req, `UCF_OFF_MLS)   ? {m_now, delta} : scr;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) reg_rdata <= rd_mux;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_isr_idle_code: assert property (
    !(rls_act || rda_act || to_act || transmit_holding_vacant_act || ms_act) |-> isr_code == 6'b000001)
    else $error("idle interrupt code wrong");
  chk_rls_first: assert property (rls_act |-> isr_code == 6'b000110)
    else $error("receive error not highest");
  chk_rx_flush: assert property (rx_flush |=> rx_cnt == 5'h00)
    else $error("receive queue not emptied");
  chk_mode_flush: assert property (mode_chg |=> rx_cnt == 5'h00 && fifo_en != $past(fifo_en))
    else $error("mode change did not flush");
  chk_tx_flush: assert property (tx_flush |=> tx_cnt == 5'h00 && !sk_valid)
    else $error("transmit queue not emptied");
  chk_byte_trig: assert property (!fifo_en |-> trig == 5'd1)
    else $error("byte mode trigger not one");
  chk_loop_hold: assert property (loop ##1 loop |-> send_request_n && terminal_ready_n)
    else $error("modem outputs active in loop-back");
  chk_dtr_drive: assert property (
    $rose(modem_line_control[`UCF_MC_DTR]) && !loop |=> !terminal_ready_n)
    else $error("terminal-ready not driven low");
  chk_overrun_flag: assert property (rx_req && !rx_wready |=> oe)
    else $error("overrun not flagged");
  chk_receive_data_present_bit: assert property (rd_lcond |=> reg_rdata[0] == ($past(rx_cnt) != 5'h00))
    else $error("data-ready bit wrong");
  chk_tout_clear: assert property (rx_pop |=> !to_pend)
    else $error("timeout not cleared by read");
  chk_break_out: assert property (character_format[`UCF_FMT_BRK] && !loop |=> !serial_out)
    else $error("break not driven");
endmodule

// file: src/ucfic_consts.svh
`ifndef UCFIC_CONSTS_SVH
`define UCFIC_CONSTS_SVH
`define UCF_OFF_DATA  3'h0
`define UCF_OFF_IEN   3'h1
`define UCF_OFF_QCTL  3'h2
`define UCF_OFF_FMT   3'h3
`define UCF_OFF_MLC   3'h4
`define UCF_OFF_LCOND 3'h5
`define UCF_OFF_MLS   3'h6
`define UCF_OFF_SCR   3'h7
`define UCF_QC_EN     0
`define UCF_QC_RXFL   1
`define UCF_QC_TXFL   2
`define UCF_QC_TRIG   7:6
`define UCF_MC_DTR    0
`define UCF_MC_RTS    1
`define UCF_MC_LOOP   4
`define UCF_MC_AFC    5
`define UCF_FMT_LEN   1:0
`define UCF_FMT_STOP  2
`define UCF_FMT_PEN   3
`define UCF_FMT_BRK   6
`define UCF_DEPTH     16
`define UCF_CAP_FIFO  5'd16
`define UCF_CAP_BYTE  5'd1
`define UCF_RESUME    5'd1
`define UCF_TX_TRIG   5'd1
`define UCF_BAUD_LAST 16'h006c
`define UCF_BIT_LAST  6'h0f
`define UCF_MID_TICK  4'h7
`define UCF_STOP15    6'h17
`define UCF_STOP2     6'h1f
`define UCF_CHAR_BASE 4'h7
`define UCF_RST_BYTE  8'h00
`endif

// file: src/ucfic_pkg.sv
package ucfic_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ucfic_req_s;

  typedef struct packed {
    logic       brk;
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } ucfic_rx_s;

  typedef enum logic [5:0] {
    ISR_NONE  = 6'b000001,
    ISR_RLS   = 6'b000110,
    ISR_RDA   = 6'b000100,
    ISR_TOUT  = 6'b001100,
    ISR_TRANSMIT_HOLDING_VACANT  = 6'b000010,
    ISR_MODEM = 6'b000000
  } ucfic_isr_e;

  typedef enum logic [2:0] {
    SH_IDLE = 3'b000, SH_START = 3'b001, SH_DATA = 3'b010,
    SH_PAR  = 3'b011, SH_STOP  = 3'b100, SH_BRKW = 3'b101
  } ucfic_sh_e;
endpackage

// file: src/ucfic_fifo.sv
`timescale 1ns/1ps
`include "ucfic_consts.svh"
module ucfic_fifo #(parameter int W = 8) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         flush,
  input  wire logic [4:0]   cap,
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  input  wire logic         pop,
  output logic              wr_ready,
  output logic [W-1:0]      q,
  output logic [4:0]        count
);
  logic [W-1:0] mem [`UCF_DEPTH];
  logic [3:0]   wptr;
  logic [3:0]   rptr;
  wire          push_ok = push && wr_ready;
  wire          pop_ok  = pop && count != 5'h00;
  wire [3:0]    rptr_nx = pop_ok ? rptr + 4'h1 : rptr;

  assign wr_ready = count < cap;

  always_ff @(posedge clock) begin
    if (push_ok) mem[wptr] <= din;
  end

  // Head register, written through when a push lands on the next head
  always_ff @(posedge clock) begin
    if (sys_rst) q <= '0;
    else q <= (push_ok && wptr == rptr_nx) ? din : mem[rptr_nx];
  end

  always_ff @(posedge clock) begin
    if (sys_rst || flush) begin
      wptr  <= 4'h0;
      rptr  <= 4'h0;
      count <= 5'h00;
    end else begin
      wptr  <= push_ok ? wptr + 4'h1 : wptr;
      rptr  <= rptr_nx;
      count <= count + {4'h0, push_ok} - {4'h0, pop_ok};
    end
  end
endmodule

// file: src/ucfic_skid.sv
`timescale 1ns/1ps
module ucfic_skid (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       flush,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] d1;
  logic       v1;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;

  assign in_ready = !v1;

  always_ff @(posedge clock) begin
    if (sys_rst || flush) begin
      out_valid <= 1'b0;
      v1        <= 1'b0;
      out_data  <= 8'h00;
      d1        <= 8'h00;
    end else if (pop && !push) begin
      out_data  <= d1;
      out_valid <= v1;
      v1        <= 1'b0;
    end else if (push && !pop) begin
      if (!out_valid) begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end else begin
        d1 <= in_data;
        v1 <= 1'b1;
      end
    end else if (push && pop) begin
      out_data <= v1 ? d1 : in_data;
      d1       <= in_data;
    end
  end
endmodule

// file: testbench/ucfic_far_end.sv
`timescale 1ns/1ps
module ucfic_far_end (
  input  wire logic clock,
  input  wire logic serial_out,
  output logic      serial_in,
  output logic      clear_to_send_n
);
  initial begin
    serial_in = 1'b1;
    clear_to_send_n = 1'b1;
  end
  // Eight data bits, one stop, line idles high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      serial_in = f[i];
      repeat (1744) @(posedge clock);
    end
  endtask
  task automatic toggle_cts();
    @(negedge clock);
    clear_to_send_n = ~clear_to_send_n;
  endtask
  // Samples start, eight data bits and stop at their centres
  task automatic recv(output logic [9:0] f);
    do @(negedge clock); while (serial_out);
    repeat (872) @(negedge clock);
    for (int i = 0; i < 10; i++) begin
      f[i] = serial_out;
      if (i < 9) repeat (1744) @(negedge clock);
    end
  endtask
endmodule

// file: testbench/ucfic_channel_tb.sv
`timescale 1ns/1ps
module ucfic_channel_tb;
  import ucfic_pkg::*;
  logic             clock;
  logic             sys_rst;
  ucfic_req_s       reg_req;
  logic [7:0]       reg_rdata;
  logic             reg_rvalid;
  logic             serial_in;
  logic             serial_out;
  logic             send_request_n;
  logic             terminal_ready_n;
  logic             cts_n;
  int               miscompares = 0;
  int               compares = 0;
  int unsigned      seed = 4379;
  logic [7:0]       q[$];
  logic [7:0]       b;
  logic [9:0]       r;

  ucfic_channel uut (.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .serial_in(serial_in),
    .serial_out(serial_out), .send_request_n(send_request_n),
    .terminal_ready_n(terminal_ready_n), .clear_to_send_n(cts_n),
    .data_set_ready_n(1'b1), .ring_detect_n(1'b1), .carrier_detect_n(1'b1));
  ucfic_far_end far (.clock(clock), .serial_out(serial_out), .serial_in(serial_in),
    .clear_to_send_n(cts_n));

  // ****************************
  // Helpers
  // ****************************
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
    reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge clock);
    reg_req = '0;
    @(negedge clock);
  endtask
  // Read answer sampled one cycle after the request edge
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    reg_req = '0;
    chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
    chk($sformatf("reg%0d", a), reg_rdata, e);
    @(negedge clock);
  endtask
  task automatic pins(input logic [2:0] e);
    repeat (3) @(negedge clock);
    chk("pins", {5'h0, serial_out, send_request_n, terminal_ready_n}, {5'h0, e});
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************
  // Clock and watchdog
  // ****************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #470000;
    miscompares++;
    complete_run();
  end

  // ****************************
  // Tests
  // ****************************
  initial begin
    reg_req = '0;
    sys_rst = 1'b1;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    pins(3'b111);
    $display("test reset done");
    op(1'b1, 3'h4, 8'h03);
    pins(3'b100);
    op(1'b1, 3'h4, 8'h13);
    pins(3'b111);
    op(1'b1, 3'h4, 8'h00);
    b = xs() & 8'hbf;
    op(1'b1, 3'h3, b);
    rd(3'h3, b);
    op(1'b1, 3'h3, 8'h43);
    pins(3'b011);
    op(1'b1, 3'h3, 8'h03);
    pins(3'b111);
    $display("test control done");
    op(1'b1, 3'h2, 8'h01);
    op(1'b1, 3'h1, 8'h05);
    rd(3'h2, 8'hc1);
    q.push_back(xs());
    b = xs();
    fork
      far.recv(r);
      begin
        op(1'b1, 3'h0, b);
        repeat (3) op(1'b1, 3'h0, xs());
        op(1'b1, 3'h2, 8'h05);
        rd(3'h5, 8'h20);
        far.send(q[$]);
      end
    join
    repeat (240) @(negedge clock);
    chk("txbyte", r[8:1], b);
    chk("txframe", {6'h0, r[9], r[0]}, 8'h02);
    rd(3'h5, 8'h61);
    rd(3'h2, 8'hc4);
    op(1'b1, 3'h4, 8'h22);
    pins(3'b111);
    rd(3'h0, q.pop_front());
    pins(3'b101);
    op(1'b1, 3'h4, 8'h00);
    rd(3'h5, 8'h60);
    op(1'b1, 3'h2, 8'h43);
    far.send(xs());
    rd(3'h2, 8'hc1);
    rd(3'h5, 8'h61);
    op(1'b1, 3'h2, 8'h43);
    rd(3'h5, 8'h60);
    far.send(xs());
    op(1'b1, 3'h2, 8'h00);
    rd(3'h5, 8'h60);
    $display("test fifo done");
    q.push_back(xs());
    far.send(q[$]);
    far.send(xs());
    rd(3'h2, 8'h06);
    rd(3'h5, 8'h63);
    rd(3'h5, 8'h61);
    rd(3'h2, 8'h04);
    rd(3'h0, q.pop_front());
    rd(3'h6, 8'h03);
    op(1'b1, 3'h1, 8'h08);
    far.toggle_cts();
    repeat (4) @(negedge clock);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h11);
    rd(3'h2, 8'h01);
    op(1'b1, 3'h1, 8'h02);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    $display("test status done");
    complete_run();
  end
endmodule
